// file: hdl/sptg_pkg.sv
`default_nettype none
// Shared constants of the stepper pulse train generator
package sptg_pkg;
	// Structure
	localparam int NUM_UNITS = 4;
	localparam int CNT_W     = 16;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;

	// Per-unit register block: base = unit * UNIT_STRIDE
	localparam logic [ADDR_W-1:0] UNIT_STRIDE  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PRESET   = 8'h0c;
	localparam logic [ADDR_W-1:0] UNIT_SPAN    = 8'h40;

	// Shared registers
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_CLEAR     = 8'h44;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h48;
	localparam logic [ADDR_W-1:0] OFS_PORT_DIR  = 8'h4c;
	localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 8'h50;

	// Control register fields
	localparam int CTRL_OUT_EN_BIT = 0;
	localparam int CTRL_RUN_BIT    = 2;
	localparam int CTRL_BUSY_BIT   = 3;

	// Status register fields: done flags low, busy flags above
	localparam int STAT_DONE_LSB = 0;
	localparam int STAT_BUSY_LSB = 4;

	// Values after reset
	localparam logic [NUM_UNITS-1:0] RST_FLAGS = 4'h0;
	localparam logic [CNT_W-1:0]     RST_WORD  = 16'h0000;
	localparam logic [DATA_W-1:0]    RST_DATA  = 32'h0000_0000;
endpackage
`default_nettype wire

// file: hdl/sptg_channel.sv
`timescale 1ns/1ps
`default_nettype none
// One pulse train generator: count pulses, each (prescale+1) clocks high and low
module sptg_channel #(
	parameter int CNT_W = sptg_pkg::CNT_W
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] count,
	input  wire logic [CNT_W-1:0] prescale,
	output logic                  pulse,
	output logic                  busy,
	output logic                  done,
	output logic [CNT_W-1:0]      remaining
);
	typedef enum logic [1:0] {SPTG_IDLE, SPTG_HIGH, SPTG_LOW} sptg_state_t;

	sptg_state_t      state;
	sptg_state_t      next_state;
	logic [CNT_W-1:0] div;
	logic [CNT_W-1:0] next_div;
	logic [CNT_W-1:0] next_remaining;
	logic             next_pulse;
	logic             next_done;
	logic             terminal;

	// Compare with >= so a prescale lowered mid-phase ends the phase at once
	assign terminal = (div >= prescale);
	assign busy     = (state != SPTG_IDLE);

	// Next state of the run sequencer
	always_comb begin
		next_state     = state;
		next_div       = div;
		next_remaining = remaining;
		next_pulse     = pulse;
		next_done      = 1'b0;
		if (start) begin
			next_div = '0;
			if (count == '0) begin
				next_state     = SPTG_IDLE; // Empty run completes at once
				next_remaining = '0;
				next_pulse     = 1'b0;
				next_done      = 1'b1;
			end else begin
				next_state     = SPTG_HIGH;
				next_remaining = count;
				next_pulse     = 1'b1;
			end
		end else begin
			case (state)
				SPTG_IDLE: begin
					next_pulse = 1'b0;
				end
				SPTG_HIGH: begin
					if (terminal) begin
						next_state = SPTG_LOW;
						next_div   = '0;
						next_pulse = 1'b0;
					end else begin
						next_div = div + 1'b1;
					end
				end
				SPTG_LOW: begin
					if (!terminal) begin
						next_div = div + 1'b1;
					end else if (remaining == CNT_W'(1)) begin
						next_state     = SPTG_IDLE;
						next_div       = '0;
						next_remaining = '0;
						next_done      = 1'b1;
					end else begin
						next_state     = SPTG_HIGH;
						next_div       = '0;
						next_remaining = remaining - 1'b1;
						next_pulse     = 1'b1;
					end
				end
				default: begin
					next_state = SPTG_IDLE;
					next_pulse = 1'b0;
				end
			endcase
		end
	end

	// Registers of the sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= SPTG_IDLE;
			div       <= '0;
			remaining <= '0;
			pulse     <= 1'b0;
			done      <= 1'b0;
		end else begin
			state     <= next_state;
			div       <= next_div;
			remaining <= next_remaining;
			pulse     <= next_pulse;
			done      <= next_done;
		end
	end
endmodule
`default_nettype wire

// file: hdl/sptg_top.sv
// Function
// - Four generators run independently, each with own settings, counter and pin.
// - Each run emits exactly the programmed pulses, equal high and low time.
// - With the pin unused a generator still works as an interrupting timer.
// - A 16-bit prescale from 0 to 65535 sets the pulse rate.
// - A 16-bit pulse count from 0 to 65535 sets pulses per run.
// - Output enable 0 keeps pulses off the pin, 1 drives them out.
// - Interrupt enable 1 requests an interrupt at run completion, 0 does not.
// - Setup may start at once (run bit 1) or stay stopped (0).
// - Writing a new count starts a new run, other settings kept.
// - Generators one to four drive port E bits 0 to 3 when set to output.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sptg_top #(
	parameter int NUM_UNITS = sptg_pkg::NUM_UNITS,
	parameter int CNT_W     = sptg_pkg::CNT_W
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [sptg_pkg::ADDR_W-1:0] paddr,
	input  wire logic [sptg_pkg::DATA_W-1:0] pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [sptg_pkg::DATA_W-1:0] prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic                             irq,
	output logic      [NUM_UNITS-1:0]        port_e_out,
	output logic      [NUM_UNITS-1:0]        port_e_oe_n
);
	// Register map: one block of four words per generator, based at 0x10 * unit
	//   +0x0 control: bit 0 drives pulses to the pin, bit 2 starts a run, bit 3 busy
	//   +0x4 prescale: every high and every low phase lasts prescale + 1 clocks
	//   +0x8 count: a write stores the count and restarts; a read gives pulses left
	//   +0xc preset: stores a count for a later start without starting
	// Shared words above the unit blocks:
	//   0x40 status: done flags in bits 3:0, busy flags in bits 7:4
	//   0x44 clear: a 1 drops that done flag; the word reads zero
	//   0x48 interrupt enable, one bit per generator
	//   0x4c pin direction, 1 drives the pin
	//   0x50 pin latch, shown while a generator's pulse output is off
	// Anything else, or an unaligned address, answers with pslverr and reads zero
	// The start bit reads zero, so a read-modify-write of control never restarts a run
	// Unit words merge byte lanes; shared words take effect only with lane 0 enabled
	// Prescale is read live: lowering it in a phase ends that phase at the next clock

	// Register state
	logic [NUM_UNITS-1:0]        out_en;
	logic [NUM_UNITS-1:0]        next_out_en;
	logic [NUM_UNITS-1:0]        completion_irq_enable;
	logic [NUM_UNITS-1:0]        next_completion_irq_enable;
	logic [NUM_UNITS-1:0]        port_dir;
	logic [NUM_UNITS-1:0]        next_port_dir;
	logic [NUM_UNITS-1:0]        port_data;
	logic [NUM_UNITS-1:0]        next_port_data;
	logic [NUM_UNITS-1:0]        done_flag;
	logic [NUM_UNITS-1:0]        next_done_flag;
	logic [NUM_UNITS-1:0]        start;
	logic [NUM_UNITS-1:0]        next_start;
	logic [NUM_UNITS-1:0]        next_port_e_out;
	logic [NUM_UNITS-1:0]        next_port_e_oe_n;
	logic [CNT_W-1:0]            prescale      [NUM_UNITS];
	logic [CNT_W-1:0]            next_prescale [NUM_UNITS];
	logic [CNT_W-1:0]            preset        [NUM_UNITS];
	logic [CNT_W-1:0]            next_preset   [NUM_UNITS];
	logic [sptg_pkg::DATA_W-1:0] next_prdata;
	logic                        next_pslverr;

	// Generator outputs
	logic [NUM_UNITS-1:0]        pulse;
	logic [NUM_UNITS-1:0]        busy;
	logic [NUM_UNITS-1:0]        done_evt;
	logic [CNT_W-1:0]            remaining [NUM_UNITS];

	// Bus qualifiers
	logic                        setup_ph;
	logic                        wr_acc;

	// Merge write data into an old word lane by lane
	function automatic logic [31:0] sptg_merge(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = wdata[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Word offset inside a unit block
	function automatic logic [sptg_pkg::ADDR_W-1:0] sptg_unit_ofs(
		input logic [sptg_pkg::ADDR_W-1:0] a
	);
		return a & (sptg_pkg::UNIT_STRIDE - 8'h01);
	endfunction

	// Unit number of a unit-block address
	function automatic int sptg_unit_idx(
		input logic [sptg_pkg::ADDR_W-1:0] a
	);
		return int'(a / sptg_pkg::UNIT_STRIDE);
	endfunction

	// True for every mapped, word-aligned address
	function automatic logic sptg_mapped(
		input logic [sptg_pkg::ADDR_W-1:0] a
	);
		logic ok;
		ok = 1'b0;
		if (a[1:0] == 2'h0) begin
			ok = (a < sptg_pkg::UNIT_SPAN) ||
			     (a == sptg_pkg::OFS_STATUS) ||
			     (a == sptg_pkg::OFS_CLEAR) ||
			     (a == sptg_pkg::OFS_IRQ_EN) ||
			     (a == sptg_pkg::OFS_PORT_DIR) ||
			     (a == sptg_pkg::OFS_PORT_DATA);
		end
		return ok;
	endfunction

	// Zero wait states: read data is registered in the setup cycle
	assign pready   = 1'b1;
	assign setup_ph = psel && !penable;
	assign wr_acc   = psel && penable && pwrite;

	// One generator per unit, no shared state between them
	for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
		sptg_channel #(
			.CNT_W (CNT_W)
		) u_channel (
			.pclk      (pclk),
			.presetn   (presetn),
			.start     (start[u]),
			.count     (preset[u]),
			.prescale  (prescale[u]),
			.pulse     (pulse[u]),
			.busy      (busy[u]),
			.done      (done_evt[u]),
			.remaining (remaining[u])
		);
	end

	// Next values of the register file, start strobes, read data and error
	always_comb begin
		logic [31:0] merged;
		logic [31:0] rd;
		int          ui;
		merged                     = sptg_pkg::RST_DATA;
		rd                         = sptg_pkg::RST_DATA;
		ui                         = sptg_unit_idx(paddr);
		next_out_en                = out_en;
		next_completion_irq_enable = completion_irq_enable;
		next_port_dir              = port_dir;
		next_port_data             = port_data;
		next_start                 = '0;
		next_prescale              = prescale;
		next_preset                = preset;
		next_prdata                = prdata;
		next_pslverr               = pslverr;

		// Unit block writes
		if (wr_acc && sptg_mapped(paddr) && paddr < sptg_pkg::UNIT_SPAN && ui < NUM_UNITS) begin
			case (sptg_unit_ofs(paddr))
				sptg_pkg::OFS_CTRL: begin
					merged = sptg_merge({31'h0, out_en[ui]}, pwdata, pstrb);
					next_out_en[ui] = merged[sptg_pkg::CTRL_OUT_EN_BIT];
					// Run bit 0 only stores settings; a start may follow later
					if (pstrb[0] && pwdata[sptg_pkg::CTRL_RUN_BIT]) begin
						next_start[ui] = 1'b1;
					end
				end
				sptg_pkg::OFS_PRESCALE: begin
					merged = sptg_merge({16'h0, prescale[ui]}, pwdata, pstrb);
					next_prescale[ui] = merged[CNT_W-1:0];
				end
				sptg_pkg::OFS_COUNT: begin
					merged = sptg_merge({16'h0, preset[ui]}, pwdata, pstrb);
					next_preset[ui] = merged[CNT_W-1:0];
					// Enables are untouched; only the run restarts
					next_start[ui] = |pstrb;
				end
				sptg_pkg::OFS_PRESET: begin
					merged = sptg_merge({16'h0, preset[ui]}, pwdata, pstrb);
					next_preset[ui] = merged[CNT_W-1:0];
				end
				default: begin
					merged = sptg_pkg::RST_DATA;
				end
			endcase
		end

		// Shared register writes
		if (wr_acc && pstrb[0]) begin
			case (paddr)
				sptg_pkg::OFS_IRQ_EN: begin
					next_completion_irq_enable = pwdata[NUM_UNITS-1:0];
				end
				sptg_pkg::OFS_PORT_DIR: begin
					next_port_dir = pwdata[NUM_UNITS-1:0];
				end
				sptg_pkg::OFS_PORT_DATA: begin
					next_port_data = pwdata[NUM_UNITS-1:0];
				end
				default: begin
					next_port_data = port_data;
				end
			endcase
		end

		// Read data and error are prepared in the setup cycle
		if (setup_ph) begin
			next_pslverr = !sptg_mapped(paddr);
			if (paddr < sptg_pkg::UNIT_SPAN && ui < NUM_UNITS) begin
				case (sptg_unit_ofs(paddr))
					sptg_pkg::OFS_CTRL: begin
						rd[sptg_pkg::CTRL_OUT_EN_BIT] = out_en[ui];
						rd[sptg_pkg::CTRL_BUSY_BIT]   = busy[ui];
					end
					sptg_pkg::OFS_PRESCALE: rd[CNT_W-1:0] = prescale[ui];
					sptg_pkg::OFS_COUNT:    rd[CNT_W-1:0] = remaining[ui];
					sptg_pkg::OFS_PRESET:   rd[CNT_W-1:0] = preset[ui];
					default:                rd = sptg_pkg::RST_DATA;
				endcase
			end else begin
				case (paddr)
					sptg_pkg::OFS_STATUS: begin
						rd[sptg_pkg::STAT_DONE_LSB +: NUM_UNITS] = done_flag;
						rd[sptg_pkg::STAT_BUSY_LSB +: NUM_UNITS] = busy;
					end
					sptg_pkg::OFS_IRQ_EN:    rd[NUM_UNITS-1:0] = completion_irq_enable;
					sptg_pkg::OFS_PORT_DIR:  rd[NUM_UNITS-1:0] = port_dir;
					sptg_pkg::OFS_PORT_DATA: rd[NUM_UNITS-1:0] = port_data;
					default:                 rd = sptg_pkg::RST_DATA; // Clear register reads zero
				endcase
			end
			next_prdata = pwrite ? sptg_pkg::RST_DATA : rd;
		end
	end

	// Done flags: a completion in the clearing cycle survives the clear
	always_comb begin
		next_done_flag = done_flag;
		if (wr_acc && pstrb[0] && paddr == sptg_pkg::OFS_CLEAR) begin
			next_done_flag = done_flag & ~pwdata[NUM_UNITS-1:0];
		end
		next_done_flag = next_done_flag | done_evt;
	end

	// Pins: pulses when enabled, else the port latch; idle level is low
	always_comb begin
		for (int p = 0; p < NUM_UNITS; p++) begin
			next_port_e_out[p]  = out_en[p] ? pulse[p] : port_data[p];
			next_port_e_oe_n[p] = !port_dir[p];
		end
	end

	// Interrupt works with the pin disabled, so a unit doubles as a timer
	assign irq = |(done_flag & completion_irq_enable);

	// Register stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_en                <= sptg_pkg::RST_FLAGS;
			completion_irq_enable <= sptg_pkg::RST_FLAGS;
			port_dir              <= sptg_pkg::RST_FLAGS;
			port_data             <= sptg_pkg::RST_FLAGS;
			done_flag             <= sptg_pkg::RST_FLAGS;
			start                 <= sptg_pkg::RST_FLAGS;
			port_e_out            <= sptg_pkg::RST_FLAGS;
			port_e_oe_n           <= ~sptg_pkg::RST_FLAGS; // Pins released
			prdata                <= sptg_pkg::RST_DATA;
			pslverr               <= 1'b0;
			for (int r = 0; r < NUM_UNITS; r++) begin
				prescale[r] <= sptg_pkg::RST_WORD;
				preset[r]   <= sptg_pkg::RST_WORD;
			end
		end else begin
			out_en                <= next_out_en;
			completion_irq_enable <= next_completion_irq_enable;
			port_dir              <= next_port_dir;
			port_data             <= next_port_data;
			done_flag             <= next_done_flag;
			start                 <= next_start;
			port_e_out            <= next_port_e_out;
			port_e_oe_n           <= next_port_e_oe_n;
			prdata                <= next_prdata;
			pslverr               <= next_pslverr;
			prescale              <= next_prescale;
			preset                <= next_preset;
		end
	end
endmodule
`default_nettype wire

// file: verif/sptg_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module sptg_checker #(
	parameter int NUM_UNITS = 4
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 irq,
	input wire logic [NUM_UNITS-1:0] port_e_oe_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic rd;
	logic w_dir;
	logic w_irq;
	// Decoded access phases, kept apart so each property stays short
	assign acc   = psel && penable;
	assign rd    = acc && !pwrite;
	assign w_dir = acc && pwrite && paddr == sptg_pkg::OFS_PORT_DIR;
	assign w_irq = acc && pwrite && (paddr == sptg_pkg::OFS_CLEAR || paddr == sptg_pkg::OFS_IRQ_EN);
	property p_ready;
		acc |-> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("access cycle without ready");
	property p_unaligned;
		acc && paddr[1:0] != 2'h0 |-> pslverr;
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
	property p_unmapped;
		rd && paddr > 8'h50 |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_mapped;
		rd && paddr <= 8'h50 && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped read refused");
	property p_hi_zero;
		rd && paddr < 8'h40 |-> prdata[31:16] == 16'h0000;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("unit register wider than 16 bits");
	property p_run_reads0;
		rd && paddr < 8'h40 && paddr[3:0] == 4'h0 |-> !prdata[2];
	endproperty
	a_run_reads0: assert property (p_run_reads0) else $error("start bit reads back set");
	property p_clear_reads0;
		rd && paddr == sptg_pkg::OFS_CLEAR |-> prdata == 32'h0000_0000;
	endproperty
	a_clear_reads0: assert property (p_clear_reads0) else $error("clear register not zero");
	property p_prdata_hold;
		!(psel && !penable) |=> $stable(prdata);
	endproperty
	a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved outside setup");
	// Pin direction only follows a direction write, one or two flops late
	property p_oe_dir;
		$changed(port_e_oe_n) |-> $past(w_dir, 1) || $past(w_dir, 2);
	endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("pin enable moved without write");
	// Done flags are sticky, so the interrupt only drops on clear or mask
	property p_irq_fall;
		$fell(irq) |-> $past(w_irq, 1) || $past(w_irq, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
endmodule
bind sptg_top sptg_checker #(.NUM_UNITS(NUM_UNITS)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .port_e_oe_n(port_e_oe_n));
`default_nettype wire

// file: verif/sptg_stepper_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Shift/rotate phase sequencer clocked by one pulse train
module sptg_stepper_seq (
	input wire logic       step_clk,
	input wire logic       load,
	input wire logic       dir,
	input wire logic [3:0] setup_bus,
	output logic     [3:0] phase
);
	// Load is a level so the pattern sits ready before the first step edge
	always @(posedge step_clk or posedge load) begin
		if (load)
			phase <= setup_bus;
		else if (dir)
			phase <= {phase[2:0], phase[3]};
		else
			phase <= {phase[0], phase[3:1]};
	end
endmodule
`default_nettype wire

// file: verif/sptg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sptg_top_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  pstrb, port_e_out, port_e_oe_n, pin, prev, seq_load, seq_dir, seq_bus;
	logic [3:0]  phase [4];
	logic        e;
	int          errors, n_checks, rises [4], hi_len [4], lo_len [4];

	sptg_top #(.NUM_UNITS(4), .CNT_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .port_e_out(port_e_out), .port_e_oe_n(port_e_oe_n));
	// Pins have pull-downs, so an undriven pin reads low
	assign pin = port_e_out & ~port_e_oe_n;
	for (genvar u = 0; u < 4; u++) begin : g_seq
		sptg_stepper_seq seq (.step_clk(pin[u]), .load(seq_load[u]), .dir(seq_dir[u]), .setup_bus(seq_bus),
			.phase(phase[u]));
	end

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One APB transfer; waits for ready as long as it takes, the watchdog bounds a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
		chk(32'(e), 32'(err));
	endtask
	task automatic chk_irq(input logic exp);
		@(negedge pclk);
		chk(32'(irq), 32'(exp));
	endtask
	// Poll the done flags, bounded
	task automatic wait_done(input logic [3:0] m);
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h40, 32'h0);
			n++;
		end while ((q[3:0] & m) !== m && n < 100);
		chk(32'(q[3:0] & m), 32'(m));
	endtask
	function automatic logic [3:0] rot(input logic [3:0] p, input int n, input logic left);
		for (int i = 0; i < n; i++)
			p = left ? {p[2:0], p[3]} : {p[0], p[3:1]};
		return p;
	endfunction

	// Measure every high phase and each low phase between two pulses away from the launching edge
	always @(negedge pclk) begin
		for (int u = 0; u < 4; u++) begin
			if (pin[u] && !prev[u]) begin
				rises[u]++;
				if (lo_len[u] > 0)
					chk(32'(lo_len[u]), 32'(u + 1));
				hi_len[u] = 0;
			end
			if (!pin[u] && prev[u]) begin
				chk(32'(hi_len[u]), 32'(u + 1));
				lo_len[u] = 0;
			end
			if (pin[u])
				hi_len[u]++;
			else if (lo_len[u] >= 0)
				lo_len[u]++;
			prev[u] = pin[u];
		end
	end

	initial begin
		#100us;
		errors++;
		stop_test;
	end

	initial begin
		errors = 0;
		n_checks = 0;
		{psel, penable, pwrite, presetn, prev} = '0;
		{paddr, pwdata, seq_load, seq_bus} = '0;
		pstrb = 4'hf;
		seq_dir = 4'h5;
		for (int u = 0; u < 4; u++) begin
			rises[u] = 0;
			lo_len[u] = -1;
		end
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 'h50; a += 4)
			rd(8'(a), 32'h0, 1'b0);
		chk(32'(port_e_oe_n), 32'hf);
		rd(8'h54, 32'h0, 1'b1);
		rd(8'h61, 32'h0, 1'b1);
		apb(1'b1, 8'h14, 32'hffff_ffff);
		rd(8'h14, 32'h0000_ffff, 1'b0);
		apb(1'b1, 8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0000_ffff, 1'b0);
		// Sequencer patterns go in before any train starts
		@(posedge pclk);
		seq_bus <= 4'h3;
		seq_load <= 4'hf;
		@(posedge pclk);
		seq_load <= 4'h0;
		apb(1'b1, 8'h4c, 32'hf);
		for (int u = 0; u < 4; u++) begin
			apb(1'b1, 8'(16 * u + 4), 32'(u));
			apb(1'b1, 8'(16 * u + 12), 32'(u + 2));
			apb(1'b1, 8'(16 * u), 32'h1);
		end
		for (int u = 0; u < 4; u++)
			apb(1'b1, 8'(16 * u), 32'h5);
		rd(8'h30, 32'h0000_0009, 1'b0);
		wait_done(4'hf);
		rd(8'h40, 32'hf, 1'b0);
		chk_irq(1'b0);
		chk(32'(pin), 32'h0);
		for (int u = 0; u < 4; u++) begin
			chk(32'(rises[u]), 32'(u + 2));
			chk(32'(phase[u]), 32'(rot(4'h3, u + 2, seq_dir[u])));
		end
		apb(1'b1, 8'h44, 32'hf);
		rd(8'h40, 32'h0, 1'b0);
		// Unit two as a bare timer, unit one restarted by a count write
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h48, 32'h2);
		apb(1'b1, 8'h18, 32'h3);
		// The idle gap since the last run is no low phase of a pulse
		lo_len[0] = -1;
		apb(1'b1, 8'h08, 32'h2);
		apb(1'b0, 8'h00, 32'h0);
		chk(q & 32'h1, 32'h1);
		wait_done(4'h3);
		chk(32'(rises[1]), 32'h3);
		chk_irq(1'b1);
		apb(1'b1, 8'h48, 32'h0);
		chk_irq(1'b0);
		apb(1'b1, 8'h48, 32'h2);
		chk_irq(1'b1);
		apb(1'b1, 8'h44, 32'h2);
		chk_irq(1'b0);
		rd(8'h40, 32'h1, 1'b0);
		apb(1'b1, 8'h44, 32'h1);
		apb(1'b1, 8'h28, 32'h0);
		wait_done(4'h4);
		chk(32'(rises[2]), 32'h4);
		stop_test;
	end
endmodule
`default_nettype wire
